/* rtl/mvic_ctrl.sv */
// multilevel vectored interrupt controller with ahb-lite register slave
//
// Functional notes
// R1: peripheral raises its request only while its flag and enable are both set.
// R2: accepted request pushes pc and status word, then branches; three cycles total.
// R3: return from interrupt restores saved pc and previous interrupt level.
// R4: global enable bit 7 gates every request except top level.
// R5: requests at or below the level in service are not accepted.
// R6: level in service is held in status word bits 8 to 10.
// R7: highest level wins, then lowest vector address.
// R8: requests in the first two cycles after standby release are refused.
// R9: acceptance blocked right before halt or standby entry.
// R10: no interrupt between a return and the next instruction.
// R11: four level registers set each vector's level or disable; reset zero.
// R12: exceptions enabled only by exception registers, ignore global enable.
// R13: no peripheral interrupt accepted while an exception is in service.
// R14: one shared exception vector for five sources, above all peripherals.
// R15: sixteen peripheral vectors spaced four apart from the base vector.
// R16: low exception register holds flag and enable pairs for four exceptions.
// R17: level field 11 is level 3, 10 level 2, 01 level 1, 00 disabled.
// R18: exception register writes take effect only while write permit bit is set.
// R19: accepting a request loads its level into the status word level field.
`timescale 1ns/1ps
`include "mvic_consts.svh"

module mvic_ctrl #(
	parameter int NVEC       = 16,
	parameter int NEST_DEPTH = 5
) (
	input  wire logic                 clk_sys_in,
	input  wire logic                 resetn_in,
	// ahb-lite slave
	input  wire logic                 hsel_in,
	input  wire logic [31:0]          haddr_in,
	input  wire logic [1:0]           htrans_in,
	input  wire logic                 hwrite_in,
	input  wire logic [2:0]           hsize_in,
	input  wire logic [31:0]          hwdata_in,
	input  wire logic                 hready_in,
	output logic      [31:0]          hrdata_out,
	output logic                      hreadyout_out,
	output logic                      hresp_out,
	// peripheral requests and exception events
	input  wire logic [NVEC-1:0]      irq_req_in,
	input  wire logic [3:0]           exc_event_low_in,
	input  wire logic                 exc_event_uart_in,
	// core side
	input  wire logic [15:0]          cpu_status_word_in,
	input  wire logic                 instr_boundary_in,
	input  wire logic                 halt_entry_in,
	input  wire logic                 deep_standby_release_in,
	input  wire logic                 return_from_irq_in,
	output logic                      save_pc_out,
	output logic                      save_psw_out,
	output logic                      vector_load_out,
	output mvic_pkg::mvic_vector_t    vector_addr_out,
	output logic                      psw_level_load_out,
	output mvic_pkg::mvic_level_t     psw_level_out,
	output logic                      irq_out
);
	import mvic_pkg::*;

	// level of vector i from the packed level registers
	function automatic mvic_level_t vec_level(input logic [31:0] lv, input int i);
		logic [1:0] f;
		f = lv[2*i +: 2];
		// R17: 00 disabled, else level equals field
		vec_level = {1'b0, f};
	endfunction

	// register index from a byte address
	function automatic logic [15:0] reg_index(input logic [31:0] a);
		reg_index = a[17:2];
	endfunction

	// registers
	logic [31:0]        level_reg;        // four level registers packed
	logic [7:0]         exc_low_reg;
	logic [7:0]         exc_high_reg;
	logic [2:0]         evt_stat_reg;
	logic [2:0]         evt_en_reg;
	mvic_state_t        state_reg;
	mvic_level_t        nest_mem [NEST_DEPTH];
	logic [2:0]         nest_sp_reg;
	logic [1:0]         wake_cnt_reg;
	logic               ret_block_reg;
	logic               take_exc_reg;
	mvic_vector_t       pend_vec_reg;
	mvic_level_t        pend_lvl_reg;
	logic               dph_wr_reg;
	logic               dph_rd_reg;
	logic [15:0]        dph_idx_reg;

	// ahb address phase decode
	wire logic          addr_ok   = hsel_in & htrans_in[1] & hready_in;
	wire logic          wr_start  = addr_ok & hwrite_in;
	wire logic          rd_start  = addr_ok & ~hwrite_in;
	wire logic [7:0]    wbyte     = hwdata_in[7:0];
	wire logic          wr_lvl1l  = dph_wr_reg & (dph_idx_reg == `MVIC_IDX_LVL1_LOW);
	wire logic          wr_lvl1h  = dph_wr_reg & (dph_idx_reg == `MVIC_IDX_LVL1_HIGH);
	wire logic          wr_lvl2l  = dph_wr_reg & (dph_idx_reg == `MVIC_IDX_LVL2_LOW);
	wire logic          wr_lvl2h  = dph_wr_reg & (dph_idx_reg == `MVIC_IDX_LVL2_HIGH);
	wire logic          wp_ok     = cpu_status_word_in[`MVIC_PSW_WP_BIT];
	// R18: exception registers writable only with write permit
	wire logic          wr_excl   = dph_wr_reg & wp_ok & (dph_idx_reg == `MVIC_IDX_EXC_LOW);
	wire logic          wr_exch   = dph_wr_reg & wp_ok & (dph_idx_reg == `MVIC_IDX_EXC_HIGH);
	wire logic          wr_evclr  = dph_wr_reg & (dph_idx_reg == `MVIC_IDX_EVT_CLR);
	wire logic          wr_even   = dph_wr_reg & (dph_idx_reg == `MVIC_IDX_EVT_EN);

	// core status fields
	wire logic          ie_bit    = cpu_status_word_in[`MVIC_PSW_IE_BIT];
	// R6: level in service from status word bits 8..10
	wire mvic_level_t   cur_lvl   = cpu_status_word_in[`MVIC_PSW_LVL_HI:`MVIC_PSW_LVL_LO];

	// exception flags: hardware sets at bits 7,5,3,1; enables at 6,4,2,0
	// R16: four flag/enable pairs in the low register
	wire logic [3:0]    exl_flags = {exc_low_reg[7], exc_low_reg[5], exc_low_reg[3],
	                                 exc_low_reg[1]};
	wire logic [3:0]    exl_ens   = {exc_low_reg[6], exc_low_reg[4], exc_low_reg[2],
	                                 exc_low_reg[0]};
	// R12: exception pending from its own enables only, no global enable
	wire logic          exc_pend  = (|(exl_flags & exl_ens)) |
	                                (exc_high_reg[`MVIC_EXH_U0_FLAG] &
	                                 exc_high_reg[`MVIC_EXH_U0_EN]);
	wire logic          in_exc    = (cur_lvl == `MVIC_LVL_EXC);

	// acceptance window
	// R8: standby wake block; R9: halt entry; R10: after return
	wire logic          gate_ok   = instr_boundary_in & (state_reg == MVIC_ST_IDLE) &
	                                (wake_cnt_reg == 2'h0) & ~halt_entry_in &
	                                ~ret_block_reg & ~return_from_irq_in &
	                                (nest_sp_reg < 3'(NEST_DEPTH));

	// peripheral arbitration
	logic               per_found;
	logic [3:0]         per_idx;
	mvic_level_t        per_lvl;
	always_comb begin
		mvic_level_t l;
		per_found = 1'b0;
		per_idx   = 4'h0;
		per_lvl   = `MVIC_LVL_NONE;
		l         = `MVIC_LVL_NONE;
		// R7: scan top level down, lowest vector first within a level
		for (int lv = 3; lv >= 1; lv--) begin
			for (int i = 0; i < NVEC; i++) begin
				l = vec_level(level_reg, i);
				// R4: global enable except top level; R5: strictly above current
				if (!per_found && irq_req_in[i] && (l == 3'(lv)) &&
				    (ie_bit || l == `MVIC_LVL_TOP) && (l > cur_lvl) && !in_exc) begin
					per_found = 1'b1;
					per_idx   = 4'(i);
					per_lvl   = l;
				end
			end
		end
	end

	// R14: exception beats any peripheral; R13: none over an exception
	wire logic          take_exc  = gate_ok & exc_pend & ~in_exc;
	wire logic          take_per  = gate_ok & ~take_exc & per_found;
	// R15: vector is base plus four per index
	wire mvic_vector_t  per_vec   = `MVIC_VEC_BASE + (`MVIC_VEC_STEP * {12'h000, per_idx});
	wire logic          ret_pop   = return_from_irq_in & (nest_sp_reg != 3'h0);

	// read mux
	logic [7:0]         rd_val;
	wire logic [15:0]   ridx      = dph_idx_reg;
	assign rd_val = (ridx == `MVIC_IDX_LVL1_LOW)  ? level_reg[7:0]   :
	                (ridx == `MVIC_IDX_LVL1_HIGH) ? level_reg[15:8]  :
	                (ridx == `MVIC_IDX_LVL2_LOW)  ? level_reg[23:16] :
	                (ridx == `MVIC_IDX_LVL2_HIGH) ? level_reg[31:24] :
	                (ridx == `MVIC_IDX_EXC_LOW)   ? exc_low_reg      :
	                (ridx == `MVIC_IDX_EXC_HIGH)  ? exc_high_reg     :
	                (ridx == `MVIC_IDX_EVT_STAT)  ? {5'h00, evt_stat_reg} :
	                (ridx == `MVIC_IDX_EVT_EN)    ? {5'h00, evt_en_reg}   :
	                (ridx == `MVIC_IDX_SVC_STAT)  ? {nest_sp_reg, state_reg, 1'b0} :
	                8'h00;

	// bus data phase tracking: writes zero wait, reads one wait
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			dph_wr_reg    <= 1'b0;
			dph_rd_reg    <= 1'b0;
			dph_idx_reg   <= 16'h0000;
			hreadyout_out <= 1'b1;
			hrdata_out    <= 32'h0000_0000;
			hresp_out     <= 1'b0;
		end else begin
			dph_wr_reg    <= wr_start;
			dph_rd_reg    <= rd_start;
			if (addr_ok) begin
				dph_idx_reg <= reg_index(haddr_in);
			end
			hreadyout_out <= ~rd_start;
			if (dph_rd_reg) begin
				hrdata_out <= {24'h000000, rd_val};
			end
		end
	end

	// R11: level registers, reset to zero
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			level_reg <= {4{`MVIC_RST_LVL}};
		end else begin
			if (wr_lvl1l) level_reg[7:0]   <= wbyte;
			if (wr_lvl1h) level_reg[15:8]  <= wbyte;
			if (wr_lvl2l) level_reg[23:16] <= wbyte;
			if (wr_lvl2h) level_reg[31:24] <= wbyte;
		end
	end

	// exception flags: events set, software writes zero to clear; set wins
	wire logic [3:0]    exl_flag_next = (wr_excl ? {wbyte[7], wbyte[5], wbyte[3], wbyte[1]}
	                                             : exl_flags) | exc_event_low_in;
	wire logic [3:0]    exl_en_next   = wr_excl ? {wbyte[6], wbyte[4], wbyte[2], wbyte[0]}
	                                            : exl_ens;
	wire logic [7:0]    exh_next      = wr_exch ? wbyte : exc_high_reg;
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			exc_low_reg  <= `MVIC_RST_EXC_LOW;
			exc_high_reg <= `MVIC_RST_EXC_HIGH;
		end else begin
			exc_low_reg  <= {exl_flag_next[3], exl_en_next[3], exl_flag_next[2],
			                 exl_en_next[2], exl_flag_next[1], exl_en_next[1],
			                 exl_flag_next[0], exl_en_next[0]};
			exc_high_reg <= exh_next | ({7'h00, exc_event_uart_in} << `MVIC_EXH_U0_FLAG);
		end
	end

	// event status: sticky, cleared by write-one, set wins
	wire logic [2:0]    evt_set  = {ret_pop, take_exc, take_per};
	wire logic [2:0]    evt_clr  = wr_evclr ? wbyte[2:0] : 3'h0;
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			evt_stat_reg <= `MVIC_RST_EVT;
			evt_en_reg   <= `MVIC_RST_EVT;
			irq_out      <= 1'b0;
		end else begin
			evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
			if (wr_even) evt_en_reg <= wbyte[2:0];
			irq_out      <= |(((evt_stat_reg & ~evt_clr) | evt_set) &
			                  (wr_even ? wbyte[2:0] : evt_en_reg));
		end
	end

	// wake and return blockers
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			wake_cnt_reg  <= 2'h0;
			ret_block_reg <= 1'b0;
		end else begin
			// R8: refuse for two cycles after standby release
			if (deep_standby_release_in) begin
				wake_cnt_reg <= `MVIC_WAKE_BLOCK_CYC;
			end else if (wake_cnt_reg != 2'h0) begin
				wake_cnt_reg <= wake_cnt_reg - 2'h1;
			end
			// R10: hold off until the instruction after the return
			if (return_from_irq_in) begin
				ret_block_reg <= 1'b1;
			end else if (instr_boundary_in) begin
				ret_block_reg <= 1'b0;
			end
		end
	end

	// entry sequence and level stack
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			state_reg          <= MVIC_ST_IDLE;
			nest_sp_reg        <= 3'h0;
			take_exc_reg       <= 1'b0;
			pend_vec_reg       <= `MVIC_VEC_BASE;
			pend_lvl_reg       <= `MVIC_LVL_NONE;
			save_pc_out        <= 1'b0;
			save_psw_out       <= 1'b0;
			vector_load_out    <= 1'b0;
			vector_addr_out    <= `MVIC_VEC_BASE;
			psw_level_load_out <= 1'b0;
			psw_level_out      <= `MVIC_LVL_NONE;
		end else begin
			save_pc_out        <= 1'b0;
			save_psw_out       <= 1'b0;
			vector_load_out    <= 1'b0;
			psw_level_load_out <= 1'b0;
			case (state_reg)
				MVIC_ST_IDLE: begin
					// R2: start push of pc on acceptance
					if (take_exc || take_per) begin
						nest_mem[nest_sp_reg] <= cur_lvl;
						nest_sp_reg  <= nest_sp_reg + 3'h1;
						take_exc_reg <= take_exc;
						pend_vec_reg <= take_exc ? `MVIC_VEC_EXC : per_vec;
						pend_lvl_reg <= take_exc ? `MVIC_LVL_EXC : per_lvl;
						save_pc_out  <= 1'b1;
						state_reg    <= MVIC_ST_SAVE_PC;
					end else if (ret_pop) begin
						// R3: restore the level saved on entry
						nest_sp_reg        <= nest_sp_reg - 3'h1;
						psw_level_out      <= nest_mem[nest_sp_reg - 3'h1];
						psw_level_load_out <= 1'b1;
					end
				end
				MVIC_ST_SAVE_PC: begin
					save_psw_out <= 1'b1;
					state_reg    <= MVIC_ST_SAVE_PSW;
				end
				MVIC_ST_SAVE_PSW: begin
					// R2: third cycle branches to vector
					vector_load_out    <= 1'b1;
					vector_addr_out    <= pend_vec_reg;
					// R19: level field takes accepted level
					psw_level_out      <= pend_lvl_reg;
					psw_level_load_out <= 1'b1;
					state_reg          <= MVIC_ST_BRANCH;
				end
				MVIC_ST_BRANCH: begin
					state_reg <= MVIC_ST_IDLE;
				end
				default: begin
					state_reg <= MVIC_ST_IDLE;
				end
			endcase
		end
	end
endmodule

/* rtl/mvic_consts.svh */
// constants for the multilevel vectored interrupt controller
`ifndef MVIC_CONSTS_SVH
`define MVIC_CONSTS_SVH

// register indexes; the bus byte address is four times the index
`define MVIC_IDX_LVL1_LOW   16'h7F02
`define MVIC_IDX_LVL1_HIGH  16'h7F03
`define MVIC_IDX_LVL2_LOW   16'h7F04
`define MVIC_IDX_LVL2_HIGH  16'h7F05
`define MVIC_IDX_EXC_LOW    16'h7F08
`define MVIC_IDX_EXC_HIGH   16'h7F09
`define MVIC_IDX_EVT_STAT   16'h7F0C
`define MVIC_IDX_EVT_CLR    16'h7F0D
`define MVIC_IDX_EVT_EN     16'h7F0E
`define MVIC_IDX_SVC_STAT   16'h7F0F

// reset values
`define MVIC_RST_LVL        8'h00
`define MVIC_RST_EXC_LOW    8'h00
`define MVIC_RST_EXC_HIGH   8'h00
`define MVIC_RST_EVT        3'h0

// status word bit positions
`define MVIC_PSW_IE_BIT     7
`define MVIC_PSW_LVL_LO     8
`define MVIC_PSW_LVL_HI     10
`define MVIC_PSW_WP_BIT     11

// exception high register: uart0 flag at bit 5, enable at bit 4
`define MVIC_EXH_U0_FLAG    5
`define MVIC_EXH_U0_EN      4

// levels and vectors
`define MVIC_LVL_NONE       3'h0
`define MVIC_LVL_TOP        3'h3
`define MVIC_LVL_EXC        3'h4
`define MVIC_VEC_BASE       16'h8000
`define MVIC_VEC_STEP       16'h0004
`define MVIC_VEC_EXC        16'h8080

// cycles blocked after release from deep standby
`define MVIC_WAKE_BLOCK_CYC 2'h2

// event status bits
`define MVIC_EVT_PERIPH     0
`define MVIC_EVT_EXC        1
`define MVIC_EVT_RET        2

`endif

/* rtl/mvic_pkg.sv */
// types for the multilevel vectored interrupt controller
package mvic_pkg;
	typedef enum logic [3:0] {
		MVIC_ST_IDLE     = 4'b0001,
		MVIC_ST_SAVE_PC  = 4'b0010,
		MVIC_ST_SAVE_PSW = 4'b0100,
		MVIC_ST_BRANCH   = 4'b1000
	} mvic_state_t;

	typedef logic [2:0]  mvic_level_t;
	typedef logic [15:0] mvic_vector_t;
endpackage

/* verif/mvic_ctrl_assertions.sv */
// port checker for the interrupt controller
`timescale 1ns/1ps
module mvic_chk (
	input wire logic        clk_sys_in,
	input wire logic        resetn_in,
	input wire logic        hsel_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic        hready_in,
	input wire logic        hreadyout_out,
	input wire logic [15:0] cpu_status_word_in,
	input wire logic        halt_entry_in,
	input wire logic        deep_standby_release_in,
	input wire logic        return_from_irq_in,
	input wire logic        save_pc_out,
	input wire logic        save_psw_out,
	input wire logic        vector_load_out,
	input wire logic [15:0] vector_addr_out,
	input wire logic        psw_level_load_out,
	input wire logic [2:0]  psw_level_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	// peripheral entry as opposed to exception entry, and a read request
	wire per_ld = vector_load_out && psw_level_out != 3'h4;
	wire rd_req = hsel_in && htrans_in[1] && hready_in && !hwrite_in;

	// entry and return sequencing
	chk_entry_seq: assert property (
		save_pc_out |=> save_psw_out ##1 (vector_load_out && psw_level_load_out))
		else $error("entry pulses out of order");
	chk_ret_pop: assert property (
		return_from_irq_in |=> psw_level_load_out && !vector_load_out)
		else $error("return did not restore level");
	// vectors and levels
	chk_exc_vector: assert property (
		vector_load_out |-> (vector_addr_out == 16'h8080) == (psw_level_out == 3'h4))
		else $error("exception vector and level disagree");
	chk_vec_range: assert property (
		per_ld |-> vector_addr_out[15:6] == 10'h200 && vector_addr_out[1:0] == 2'h0
			&& psw_level_out != 3'h0)
		else $error("peripheral vector out of range");
	chk_nest_level: assert property (
		per_ld |-> psw_level_out > $past(cpu_status_word_in[10:8], 3))
		else $error("level not above level in service");
	chk_ie_gate: assert property (
		per_ld && psw_level_out < 3'h3 |-> $past(cpu_status_word_in[7], 3))
		else $error("low level taken with global enable off");
	// windows in which nothing may be accepted
	chk_halt_block: assert property (
		halt_entry_in |=> !save_pc_out) else $error("accepted before halt");
	chk_ret_block: assert property (
		return_from_irq_in |=> !save_pc_out) else $error("accepted right after return");
	chk_wake_block: assert property (
		deep_standby_release_in |-> ##2 !save_pc_out ##1 !save_pc_out)
		else $error("accepted during wake block");
	// bus read wait state
	chk_read_wait: assert property (
		rd_req |=> !hreadyout_out ##1 hreadyout_out) else $error("read wait state wrong");
endmodule

bind mvic_ctrl mvic_chk u_chk (
	.clk_sys_in, .resetn_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out,
	.cpu_status_word_in, .halt_entry_in, .deep_standby_release_in, .return_from_irq_in,
	.save_pc_out, .save_psw_out, .vector_load_out, .vector_addr_out, .psw_level_load_out,
	.psw_level_out
);

/* verif/mvic_core_model.sv */
// core status word and peripheral request model
`timescale 1ns/1ps
module mvic_core_model (
	input  wire logic        clk_sys_in,
	input  wire logic        resetn_in,
	input  wire logic        ie_in,
	input  wire logic        wp_in,
	input  wire logic [15:0] flag_in,
	input  wire logic [15:0] en_in,
	input  wire logic        level_load_in,
	input  wire logic [2:0]  level_in,
	output logic      [15:0] status_word_out,
	output logic      [15:0] req_out
);
	logic [2:0] level_reg;
	assign req_out = flag_in & en_in;
	// status word with level in bits 10 to 8
	assign status_word_out = {4'h0, wp_in, level_reg, ie_in, 7'h00};
	// core loads the level handed over on entry and return
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in)
			level_reg <= 3'h0;
		else if (level_load_in)
			level_reg <= level_in;
	end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_top;
	import mvic_pkg::*;
	logic         clk_sys_in = '0, resetn_in = '0, hsel_in = '0, hwrite_in = '0, rd_ph = '0;
	logic [1:0]   htrans_in = '0;
	logic [31:0]  haddr_in = '0, hwdata_in = '0, hrdata_out, rd_q[$], iq[$];
	logic [3:0]   exc_event_low_in = '0;
	logic         exc_event_uart_in = '0, instr_boundary_in = 1'h1, halt_entry_in = '0;
	logic         deep_standby_release_in = '0, return_from_irq_in = '0, ie = '0, wp = '0;
	logic [15:0]  flag = '0, en = '0, cpu_status_word_in, irq_req_in;
	logic         hreadyout_out, hresp_out, save_pc_out, save_psw_out, vector_load_out;
	logic         psw_level_load_out, irq_out;
	mvic_vector_t vector_addr_out;
	mvic_level_t  psw_level_out;
	logic [7:0]   d;
	integer       failures = 0, checks = 0, seed = 25, i;

	// design and core model
	mvic_ctrl DUT (
		.clk_sys_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
		.hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
		.hreadyout_out, .hresp_out, .irq_req_in, .exc_event_low_in, .exc_event_uart_in,
		.cpu_status_word_in, .instr_boundary_in, .halt_entry_in, .deep_standby_release_in,
		.return_from_irq_in, .save_pc_out, .save_psw_out, .vector_load_out,
		.vector_addr_out, .psw_level_load_out, .psw_level_out, .irq_out
	);
	mvic_core_model u_core (
		.clk_sys_in, .resetn_in, .ie_in(ie), .wp_in(wp), .flag_in(flag), .en_in(en),
		.level_load_in(psw_level_load_out), .level_in(psw_level_out),
		.status_word_out(cpu_status_word_in), .req_out(irq_req_in)
	);

	initial forever #12.5 clk_sys_in = ~clk_sys_in;

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one ahb-lite single transfer, held until ready is sampled high
	task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] dat);
		@(posedge clk_sys_in);
		hsel_in <= 1'h1;
		htrans_in <= 2'h2;
		hwrite_in <= wr;
		haddr_in <= {14'h0, idx, 2'h0};
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'h1);
		hsel_in <= 1'h0;
		htrans_in <= 2'h0;
		hwdata_in <= {24'h0, dat};
		rd_ph <= !wr;
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'h1);
		rd_ph <= 1'h0;
	endtask

	task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
		rd_q.push_back(exp);
		bus(idx, 1'h0, 8'h00);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] dat);
		bus(idx, 1'h1, dat);
	endtask

	task automatic note(input logic [15:0] a, input logic [2:0] l);
		iq.push_back({13'h0, a, l});
	endtask

	// wait, bounded, until every noted entry or return has shown up
	task automatic drain;
		repeat (40) if (iq.size() != 0) @(posedge clk_sys_in);
		if (iq.size() != 0)
			cmp(32'h1, 32'h0);
		repeat (2) @(posedge clk_sys_in);
	endtask

	task automatic pulse_ret;
		return_from_irq_in <= 1'h1;
		@(posedge clk_sys_in);
		return_from_irq_in <= 1'h0;
	endtask

	task automatic end_of_test;
		if (failures == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// monitor: each completed read and each level load against the oldest note
	always @(posedge clk_sys_in) begin
		if (rd_ph && hreadyout_out) begin
			cmp(hrdata_out, rd_q.pop_front());
			cmp({31'h0, hresp_out}, 32'h0);
		end
		if (vector_load_out || psw_level_load_out)
			cmp({13'h0, vector_load_out ? vector_addr_out : 16'h0, psw_level_out},
				iq.size() ? iq.pop_front() : 32'hFFFFFFFF);
	end

	// watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		failures++;
		end_of_test;
	end

	initial begin
		repeat (3) @(posedge clk_sys_in);
		resetn_in <= 1'h1;
		// reset values, unmapped places included
		for (i = 2; i < 12; i++) rd(16'h7F00 + 16'(i), 32'h0);
		for (i = 2; i < 6; i++) begin
			d = 8'($random(seed));
			wr(16'h7F00 + 16'(i), d);
			rd(16'h7F00 + 16'(i), {24'h0, d});
		end
		wr(16'h7F06, 8'hFF);
		rd(16'h7F06, 32'h0);
		// vectors 0-3 level 2, 4-7 level 3, 8-11 level 1, 12-15 off
		wr(16'h7F02, 8'hAA);
		wr(16'h7F03, 8'hFF);
		wr(16'h7F04, 8'h55);
		wr(16'h7F05, 8'h00);
		ie <= 1'h1;
		en <= 16'hFFFE;
		flag <= 16'h000B;
		note(16'h8004, 3'h2);
		drain;
		flag <= 16'h010B;
		repeat (8) @(posedge clk_sys_in);
		flag <= 16'h012B;
		note(16'h8014, 3'h3);
		drain;
		flag <= 16'h0;
		note(16'h0, 3'h2);
		pulse_ret;
		drain;
		note(16'h0, 3'h0);
		pulse_ret;
		drain;
		ie <= 1'h0;
		flag <= 16'h0110;
		note(16'h8010, 3'h3);
		drain;
		flag <= 16'h0;
		note(16'h0, 3'h0);
		pulse_ret;
		drain;
		// no boundary, then halt entry, hold the request off; release comes while halted
		instr_boundary_in <= 1'h0;
		flag <= 16'h0010;
		repeat (4) @(posedge clk_sys_in);
		instr_boundary_in <= 1'h1;
		halt_entry_in <= 1'h1;
		repeat (5) @(posedge clk_sys_in);
		deep_standby_release_in <= 1'h1;
		@(posedge clk_sys_in);
		halt_entry_in <= 1'h0;
		deep_standby_release_in <= 1'h0;
		note(16'h8010, 3'h3);
		repeat (2) @(posedge clk_sys_in);
		cmp({31'h0, save_pc_out}, 32'h0);
		drain;
		flag <= 16'h0;
		note(16'h0, 3'h0);
		pulse_ret;
		drain;
		// exception registers behind the write permit
		wp <= 1'h1;
		wr(16'h7F08, 8'h55);
		wr(16'h7F09, 8'h10);
		wp <= 1'h0;
		wr(16'h7F08, 8'h00);
		rd(16'h7F08, 32'h55);
		rd(16'h7F09, 32'h10);
		// every exception source, peripheral held off while in service
		for (i = 0; i < 5; i++) begin
			{exc_event_uart_in, exc_event_low_in} <= 5'(1 << i);
			@(posedge clk_sys_in);
			// peripheral request and exception flag pend together from here
			flag <= 16'h0010;
			{exc_event_uart_in, exc_event_low_in} <= 5'h0;
			note(16'h8080, 3'h4);
			drain;
			repeat (6) @(posedge clk_sys_in);
			flag <= 16'h0;
			wp <= 1'h1;
			wr(16'h7F08, 8'h55);
			wr(16'h7F09, 8'h10);
			wp <= 1'h0;
			note(16'h0, 3'h0);
			pulse_ret;
			drain;
		end
		// event status, enable and clear with the irq output
		rd(16'h7F0C, 32'h7);
		wr(16'h7F0E, 8'h01);
		repeat (2) @(posedge clk_sys_in);
		cmp({31'h0, irq_out}, 32'h1);
		wr(16'h7F0D, 8'h01);
		rd(16'h7F0C, 32'h6);
		cmp({31'h0, irq_out}, 32'h0);
		wr(16'h7F0D, 8'h06);
		rd(16'h7F0C, 32'h0);
		end_of_test;
	end
endmodule
